// [ssp_consts.vh]
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SSP_OFS_CTRL 8'h14
`define SSP_OFS_STATUS 8'h94
`define SSP_OFS_DATA 8'h20
`define SSP_OFS_INT_STAT 8'h24
`define SSP_OFS_INT_CLR 8'h28
`define SSP_OFS_INT_EN 8'h2C

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define SSP_CTRL_EN_BIT 5
`define SSP_CTRL_POL_BIT 4
`define SSP_CTRL_MODE_HI 3
`define SSP_CTRL_MODE_LO 0
`define SSP_CTRL_RESET 6'h00

// ----------------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------------
`define SSP_MODE_MASTER_LAST 4'h3
`define SSP_MODE_SLAVE_SS 4'h4
`define SSP_MODE_SLAVE_NOSS 4'h5
`define SSP_MODE_TWO_WIRE 4'h6

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define SSP_STAT_SMP_BIT 7
`define SSP_STAT_CKE_BIT 6
`define SSP_STAT_DA_BIT 5
`define SSP_STAT_STOP_BIT 4
`define SSP_STAT_BF_BIT 0
`define SSP_STAT_RESET 8'h00

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define SSP_INT_DONE_BIT 0
`define SSP_INT_STOP_BIT 1
`define SSP_INT_START_BIT 2
`define SSP_INT_WIDTH 3
`define SSP_INT_RESET 3'h0

// ----------------------------------------------------------------------
// timing and framing
// ----------------------------------------------------------------------
`define SSP_HALF_CYCLES 4
`define SSP_BITS 8
`define SSP_MASTER_TICKS 16
`define SSP_ADDR_BITS 9

`endif

// [ssp_spi_port.v]
// Function
// - port runs only while enable bit set
// - enable hands serial pins to the port
// - select high resets slave logic in mode 0100
// - master sample phase: end or middle
// - edge select and polarity pick transmit edge
// - two-wire data/address flag in status bit 5
// - stop flag: set on stop, clear start/disable
// - eight bits out and in per transfer
// - clock driven in master, input in slave
// - buffer full set on receive, clear when empty
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"

module ssp_spi_port #(
    parameter HALF_CYCLES = `SSP_HALF_CYCLES
) (
    input wire ref_clk, // core clock
    input wire arst_n, // async reset, active low
    input wire hsel, // slave select from decoder
    input wire [31:0] haddr, // byte address
    input wire [1:0] htrans, // transfer type
    input wire hwrite, // write when high
    input wire [2:0] hsize, // transfer size
    input wire [31:0] hwdata, // write data
    input wire hready, // bus ready in
    output wire hreadyout, // always ready
    output wire hresp, // always okay
    output reg [31:0] hrdata, // read data
    input wire sdiIn, // serial data in pin
    output wire sdoOut, // serial data out pin
    output wire sdoOe_n, // serial out drive enable
    input wire sckIn, // serial clock pin level
    output wire sckOut, // serial clock drive value
    output wire sckOe_n, // serial clock drive enable
    input wire ssIn_n, // slave select pin
    output wire irq // level interrupt
);

    // transmit edge is rising when edge select and polarity differ
    function txRise;
        input cke;
        input clock_idle_polarity;
        begin
            txRise = cke ^ clock_idle_polarity;
        end
    endfunction

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    reg [5:0] ctrl_reg;
    reg smp_reg;
    reg cke_reg;
    reg dataAddr_reg;
    reg stopSeen_reg;
    reg bufFull_reg;
    reg [7:0] rxBuf_reg;
    reg [7:0] txShift_reg;
    reg [7:0] rxShift_reg;
    reg [3:0] bitCnt_reg;
    reg busy_reg;
    reg [15:0] divCnt_reg;
    reg [4:0] tick_reg;
    reg sckLvl_reg;
    reg [2:0] intStat_reg;
    reg [2:0] intEn_reg;
    reg [7:0] dpAddr_reg;
    reg dpWrite_reg;
    reg sdiM_reg, sdiS_reg, sdiD_reg;
    reg sckM_reg, sckS_reg, sckD_reg;
    reg ssM_reg, ssS_reg;
    reg [3:0] sclCnt_reg;

    wire portEn = ctrl_reg[`SSP_CTRL_EN_BIT];
    wire clock_idle_polarity = ctrl_reg[`SSP_CTRL_POL_BIT];
    wire [3:0] mode = ctrl_reg[`SSP_CTRL_MODE_HI:`SSP_CTRL_MODE_LO];
    wire isMaster = (mode <= `SSP_MODE_MASTER_LAST);
    wire isSlaveSs = (mode == `SSP_MODE_SLAVE_SS);
    wire isSpi = (mode <= `SSP_MODE_SLAVE_NOSS);
    wire isSlave = isSpi && !isMaster;
    wire isTwoWire = !isSpi;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    // zero wait states: every access completes in its first data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire addrPhase = hsel && hready && htrans[1];
    wire wrStrobe = dpWrite_reg;
    wire rdData = addrPhase && !hwrite && (haddr[7:0] == `SSP_OFS_DATA);
    wire wrCtrl = wrStrobe && (dpAddr_reg == `SSP_OFS_CTRL);
    wire wrStat = wrStrobe && (dpAddr_reg == `SSP_OFS_STATUS);
    wire wrData = wrStrobe && (dpAddr_reg == `SSP_OFS_DATA);
    wire wrClr = wrStrobe && (dpAddr_reg == `SSP_OFS_INT_CLR);
    wire wrEn = wrStrobe && (dpAddr_reg == `SSP_OFS_INT_EN);

    wire [7:0] statusVal = {smp_reg, cke_reg, dataAddr_reg, stopSeen_reg,
                            3'h0, bufFull_reg};

    // read mux, answer registered into the data phase
    reg [31:0] rdMux;
    always @* begin
        case (haddr[7:0])
            `SSP_OFS_CTRL: rdMux = {26'h0, ctrl_reg};
            `SSP_OFS_STATUS: rdMux = {24'h0, statusVal};
            `SSP_OFS_DATA: rdMux = {24'h0, rxBuf_reg};
            `SSP_OFS_INT_STAT: rdMux = {29'h0, intStat_reg};
            `SSP_OFS_INT_EN: rdMux = {29'h0, intEn_reg};
            default: rdMux = 32'h0;
        endcase
    end

    // address phase capture and read data
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dpAddr_reg <= 8'h00;
            dpWrite_reg <= 1'b0;
            hrdata <= 32'h0;
        end else begin
            dpWrite_reg <= addrPhase && hwrite;
            if (addrPhase) begin
                dpAddr_reg <= haddr[7:0];
            end
            if (addrPhase && !hwrite) begin
                hrdata <= rdMux;
            end
        end
    end

    // control and writable status bits; disable happens here too
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `SSP_CTRL_RESET;
            smp_reg <= 1'b0;
            cke_reg <= 1'b0;
            intEn_reg <= `SSP_INT_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_reg <= hwdata[5:0];
            end
            if (wrStat) begin
                smp_reg <= hwdata[`SSP_STAT_SMP_BIT];
                cke_reg <= hwdata[`SSP_STAT_CKE_BIT];
            end
            if (wrEn) begin
                intEn_reg <= hwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two flops each; the third sdi/sck flop only serves edge finding
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdiM_reg <= 1'b1;
            sdiS_reg <= 1'b1;
            sdiD_reg <= 1'b1;
            sckM_reg <= 1'b0;
            sckS_reg <= 1'b0;
            sckD_reg <= 1'b0;
            ssM_reg <= 1'b1;
            ssS_reg <= 1'b1;
        end else begin
            sdiM_reg <= sdiIn;
            sdiS_reg <= sdiM_reg;
            sdiD_reg <= sdiS_reg;
            sckM_reg <= sckIn;
            sckS_reg <= sckM_reg;
            sckD_reg <= sckS_reg;
            ssM_reg <= ssIn_n;
            ssS_reg <= ssM_reg;
        end
    end

    // ------------------------------------------------------------------
    // shift engine
    // ------------------------------------------------------------------
    wire sckRiseS = sckS_reg && !sckD_reg;
    wire sckFallS = !sckS_reg && sckD_reg;
    wire txIsRise = txRise(cke_reg, clock_idle_polarity);
    wire ssReset = isSlaveSs && ssS_reg;
    wire slvTxEdge = txIsRise ? sckRiseS : sckFallS;
    wire slvSmpEdge = txIsRise ? sckFallS : sckRiseS;
    wire slvActive = portEn && isSlave && !ssReset;

    // compared at full width so no bits of the parameter are cut
    wire divDone = ({16'h0, divCnt_reg} == HALF_CYCLES - 1);
    wire mTick = busy_reg && divDone;
    wire tickEnd = (tick_reg == `SSP_MASTER_TICKS);
    // sample phase: odd/even tick picked by edge select and phase
    wire mSmp = mTick && (smp_reg ? ((tick_reg[0] != cke_reg)
                && (tick_reg != 5'h0)) : ((tick_reg[0] == cke_reg)
                && !tickEnd));
    wire mTx = mTick && (tick_reg[0] != cke_reg) && (tick_reg != 5'h0)
               && !tickEnd;
    wire doSmp = (isMaster ? mSmp : (slvActive && slvSmpEdge));
    wire doTx = isMaster ? mTx
                : (slvActive && slvTxEdge && (bitCnt_reg != 4'h0));
    wire lastSmp = doSmp && (bitCnt_reg == `SSP_BITS - 1);
    wire mStart = portEn && isMaster && !busy_reg && wrData;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            txShift_reg <= 8'h00;
            rxShift_reg <= 8'h00;
            bitCnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            divCnt_reg <= 16'h0;
            tick_reg <= 5'h0;
            sckLvl_reg <= 1'b0;
        end else if (!portEn || isTwoWire) begin
            bitCnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            divCnt_reg <= 16'h0;
            tick_reg <= 5'h0;
            sckLvl_reg <= clock_idle_polarity;
            if (wrData) begin
                txShift_reg <= hwdata[7:0];
            end
        end else if (ssReset) begin
            bitCnt_reg <= 4'h0;
            if (wrData) begin
                txShift_reg <= hwdata[7:0];
            end
        end else begin
            // writes while a transfer runs are dropped
            if (wrData && !busy_reg && bitCnt_reg == 4'h0) begin
                txShift_reg <= hwdata[7:0];
            end else if (doTx) begin
                txShift_reg <= {txShift_reg[6:0], 1'b0};
            end
            if (doSmp) begin
                rxShift_reg <= {rxShift_reg[6:0], sdiS_reg};
                bitCnt_reg <= lastSmp ? 4'h0 : bitCnt_reg + 4'h1;
            end
            if (mStart) begin
                busy_reg <= 1'b1;
                divCnt_reg <= 16'h0;
                tick_reg <= 5'h0;
            end else if (busy_reg) begin
                divCnt_reg <= divDone ? 16'h0 : divCnt_reg + 16'h1;
                if (mTick) begin
                    tick_reg <= tick_reg + 5'h1;
                    if (tickEnd) begin
                        busy_reg <= 1'b0;
                    end else begin
                        sckLvl_reg <= !sckLvl_reg;
                    end
                end
            end else begin
                sckLvl_reg <= clock_idle_polarity;
            end
        end
    end

    // ------------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------------
    // full on completed byte, set wins over read clear
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxBuf_reg <= 8'h00;
            bufFull_reg <= 1'b0;
        end else if (lastSmp && portEn && isSpi) begin
            rxBuf_reg <= {rxShift_reg[6:0], sdiS_reg};
            bufFull_reg <= 1'b1;
        end else if (rdData) begin
            bufFull_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // two-wire bus conditions
    // ------------------------------------------------------------------
    wire twOn = portEn && isTwoWire;
    wire startDet = twOn && sckS_reg && sckD_reg && sdiD_reg && !sdiS_reg;
    wire stopDet = twOn && sckS_reg && sckD_reg && !sdiD_reg && sdiS_reg;

    // address byte plus acknowledge precedes data
    // stop flag tracks the latest bus condition
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stopSeen_reg <= 1'b0;
            dataAddr_reg <= 1'b0;
            sclCnt_reg <= 4'h0;
        end else if (!twOn) begin
            stopSeen_reg <= 1'b0;
            dataAddr_reg <= 1'b0;
            sclCnt_reg <= 4'h0;
        end else if (startDet) begin
            stopSeen_reg <= 1'b0;
            dataAddr_reg <= 1'b0;
            sclCnt_reg <= 4'h0;
        end else begin
            if (stopDet) begin
                stopSeen_reg <= 1'b1;
            end
            if (sckRiseS && sclCnt_reg != `SSP_ADDR_BITS) begin
                sclCnt_reg <= sclCnt_reg + 4'h1;
                if (sclCnt_reg == `SSP_ADDR_BITS - 1) begin
                    dataAddr_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------------
    wire [2:0] intEvt = {startDet, stopDet, lastSmp && portEn && isSpi};

    // sticky bits; a new event beats a clear in the same cycle
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            intStat_reg <= `SSP_INT_RESET;
        end else begin
            intStat_reg <= (intStat_reg & ~(wrClr ? hwdata[2:0] : 3'h0))
                           | intEvt;
        end
    end

    assign irq = |(intStat_reg & intEn_reg);

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    // pins only driven while the port owns them
    assign sckOut = sckLvl_reg;
    assign sckOe_n = !(portEn && isMaster);
    // slave with select control releases the line while deselected
    assign sdoOut = txShift_reg[7];
    assign sdoOe_n = !(portEn && isSpi && !ssReset);

endmodule // ssp_spi_port
`default_nettype wire

// [ssp_spi_port_chk.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module ssp_spi_port_chk #(
    parameter int HALF_CYCLES = 4
) (
    input wire logic ref_clk, // core clock
    input wire logic arst_n, // async reset
    input wire logic hsel, // bus select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire logic sdoOut, // serial out
    input wire logic sdoOe_n, // serial out enable
    input wire logic sckOut, // clock drive
    input wire logic sckOe_n, // clock enable
    input wire logic irq // interrupt
);
    logic [4:0] tog;
    logic [4:0] quiet;
    wire logic rdReq = hsel && hready && htrans[1] && !hwrite;
    // master toggles per burst; a lone edge at enable is not counted
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tog <= 5'h0;
            quiet <= 5'h0;
        end else if (!sckOe_n && !$past(sckOe_n) && $changed(sckOut)) begin
            tog <= tog + 5'h1;
            quiet <= 5'h0;
        end else begin
            if (quiet != 5'h1F) quiet <= quiet + 5'h1;
            if (quiet == 5'h15) tog <= 5'h0;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    a_burst_sixteen: assert property (quiet == 5'h14 |->
        tog == 5'h0 || tog == 5'h10) else $error("sck burst not 16");
    // only valid for half periods of four cycles or more
    a_half_period: assert property (
        !sckOe_n && !$past(sckOe_n) && $changed(sckOut) |=>
        $stable(sckOut) [*3]) else $error("sck half period short");
    a_reset_idle: assert property ($rose(arst_n) |->
        sckOe_n && sdoOe_n && !irq) else $error("pins active at reset");
    a_master_drives: assert property (!sckOe_n |-> !sdoOe_n)
        else $error("master clock without data out");
    a_status_zeros: assert property (
        rdReq && haddr[7:0] == `SSP_OFS_STATUS |=>
        hrdata[31:8] == 24'h0 && hrdata[3:1] == 3'h0)
        else $error("status unused bits set");
    a_data_byte: assert property (
        rdReq && haddr[7:0] == `SSP_OFS_DATA |=> hrdata[31:8] == 24'h0)
        else $error("data wider than a byte");
    // last sample lands on toggle 15 or 16, or in the trailing half period
    a_irq_after_byte: assert property (
        $rose(irq) && !sckOe_n |-> tog == 5'h0 ||
        (tog >= 5'hE && tog <= 5'h10))
        else $error("byte done mid burst");
    a_sdo_on_edge: assert property (
        !sckOe_n && tog != 5'h0 && tog != 5'h10 && $changed(sdoOut) |->
        $changed(sckOut) || $past(sckOut, 1) != $past(sckOut, 2))
        else $error("sdo moved off a clock edge");
    c_irq: cover property ($rose(irq));
    c_burst: cover property (quiet == 5'h14 && tog == 5'h10);
    c_slave: cover property (sckOe_n && !sdoOe_n);
endmodule // ssp_spi_port_chk
bind ssp_spi_port ssp_spi_port_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .sdoOut(sdoOut), .sdoOe_n(sdoOe_n), .sckOut(sckOut),
    .sckOe_n(sckOe_n), .irq(irq));
`default_nettype wire

// [ssp_spi_peer.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external spi peer
// ----------------------------------------
module ssp_spi_peer (
    input wire logic sckOut, // device clock drive
    input wire logic sckOe_n, // device clock enable
    input wire logic sdoOut, // device data out
    input wire logic cke, // edge select in use
    input wire logic pol, // idle level in use
    output wire logic sckIn, // resolved clock wire
    output var logic sdiIn, // data to device
    output var logic ssIn_n, // select to device
    output var logic [7:0] rxByte // last byte seen
);
    logic ownSck = 1'b0;
    logic seen = 1'b0;
    logic [7:0] tx = 8'h00;
    initial ssIn_n = 1'b1;
    initial sdiIn = 1'b0;
    // device drives clock only as master
    assign sckIn = sckOe_n ? ownSck : sckOut;
    // shift on tx edge, sample on the other
    always @(sckIn) begin
        if (sckIn === (cke ^ pol)) begin
            if (seen) begin
                tx = {tx[6:0], ~tx[7]};
                sdiIn = tx[7];
            end
        end else begin
            rxByte = {rxByte[6:0], sdoOut};
            seen = 1'b1;
        end
    end
    // idle level first, so its edge cannot count as a sample
    task automatic load(input logic [7:0] b);
        ownSck = pol;
        #1;
        tx = b;
        sdiIn = b[7];
        seen = 1'b0;
    endtask
    // two-wire start (s=1) or stop (s=0): data moves while clock high
    task automatic cond(input logic s);
        ownSck = 1'b0;
        #160 sdiIn = s;
        #160 ownSck = 1'b1;
        #160 sdiIn = !s;
        #160;
    endtask
    // clock runs only inside a selected frame
    task automatic frame(input int n);
        ssIn_n = 1'b0;
        #160;
        repeat (n) #80 ownSck = ~ownSck;
        #160;
        ssIn_n = 1'b1;
        #160;
    endtask
endmodule // ssp_spi_peer
`default_nettype wire

// [tb_ssp_spi_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.vh"
module tb_ssp_spi_port;
    logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic cke = 1'b0, pol = 1'b0, rdPh = 1'b0;
    logic [7:0] pb, db;
    wire logic hreadyout, hresp, sdoOut, sdoOe_n, sckOut, sckOe_n, irq;
    wire logic sckIn, sdiIn, ssIn_n;
    wire logic [31:0] hrdata;
    wire logic [7:0] rxByte;
    logic [31:0] expQ[$];
    int badCount = 0, numChecks = 0, cyc = 0, seed;
    ssp_spi_port #(.HALF_CYCLES(`SSP_HALF_CYCLES)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sdiIn(sdiIn), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n),
        .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n), .ssIn_n(ssIn_n),
        .irq(irq));
    // peer drives only the port's inputs, select as digital
    ssp_spi_peer peer (.sckOut(sckOut), .sckOe_n(sckOe_n), .sdoOut(sdoOut),
        .cke(cke), .pol(pol), .sckIn(sckIn), .sdiIn(sdiIn),
        .ssIn_n(ssIn_n), .rxByte(rxByte));
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            badCount++;
            endOfTest();
        end
    end
    // read results meet their notes in order
    always @(posedge ref_clk) if (rdPh) check(hrdata, expQ.pop_front());
    // one single transfer; for reads d is the expected word
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= w ? d : 32'h0;
        if (!w) expQ.push_back(d);
        rdPh <= !w;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rdPh <= 1'b0;
    endtask
    // pins looked at once the last write has landed
    task automatic pins(input logic [31:0] e);
        @(posedge ref_clk);
        #1;
        check({29'h0, irq, sckOe_n, sdoOe_n}, e);
        @(posedge ref_clk);
    endtask
    task automatic cfg(input logic [3:0] m, input logic s);
        bus(1, `SSP_OFS_CTRL, 32'h0);
        bus(1, `SSP_OFS_STATUS, {24'h0, s, cke, 6'h0});
        bus(1, `SSP_OFS_CTRL, {26'h0, pol, m});
        bus(1, `SSP_OFS_CTRL, {26'h1, pol, m});
    endtask
    initial begin
        seed = $urandom(2);
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        bus(0, `SSP_OFS_CTRL, 32'h0); // off at reset
        bus(0, `SSP_OFS_STATUS, 32'h0); // clear at reset
        bus(0, `SSP_OFS_INT_STAT, 32'h0); // empty
        bus(1, `SSP_OFS_STATUS, 32'hFF);
        bus(0, `SSP_OFS_STATUS, 32'hC0); // only 7,6 writable
        bus(0, 8'h30, 32'h0); // unmapped reads zero
        bus(1, `SSP_OFS_INT_EN, 32'h1);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            pol <= i[0];
            cke <= i[1];
            @(posedge ref_clk);
            cfg({2'b00, i[1:0]}, i[2]);
            pb = $urandom;
            db = $urandom;
            peer.load(pb);
            if (i == 7) bus(1, `SSP_OFS_INT_EN, 32'h0);
            bus(1, `SSP_OFS_DATA, {24'h0, db});
            for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge ref_clk);
            pins({29'h0, i != 7, 2'b00}); // masked or raised
            check({24'h0, rxByte}, {24'h0, db}); // byte out
            bus(0, `SSP_OFS_STATUS, {24'h0, i[2], i[1], 6'h1}); // full
            bus(0, `SSP_OFS_DATA, {24'h0, pb}); // byte in
            bus(0, `SSP_OFS_STATUS, {24'h0, i[2], i[1], 6'h0}); // read
            bus(0, `SSP_OFS_INT_STAT, 32'h1); // sticky
            bus(1, `SSP_OFS_INT_EN, 32'h1);
            pins(32'h4); // unmasked
            bus(1, `SSP_OFS_INT_CLR, 32'h7);
            pins(32'h0); // cleared
        end
        $display("test master done");
        pol <= 1'b0;
        cke <= 1'b1;
        @(posedge ref_clk);
        // select control on, sample phase clear
        cfg(`SSP_MODE_SLAVE_SS, 1'b0);
        pins(32'h3); // released while deselected
        peer.load(pb);
        bus(1, `SSP_OFS_DATA, {24'h0, db});
        peer.frame(6);
        peer.load(pb);
        @(posedge ref_clk);
        bus(0, `SSP_OFS_STATUS, 32'h40); // partial byte dropped
        peer.frame(16);
        @(posedge ref_clk);
        bus(0, `SSP_OFS_STATUS, 32'h41); // full after whole frame
        bus(0, `SSP_OFS_DATA, {24'h0, pb}); // slave receive
        cke <= 1'b0;
        @(posedge ref_clk);
        cfg(`SSP_MODE_SLAVE_NOSS, 1'b0);
        bus(1, `SSP_OFS_DATA, {24'h0, db});
        peer.load(pb);
        peer.frame(16);
        @(posedge ref_clk);
        check({24'h0, rxByte}, {24'h0, db}); // slave send
        bus(0, `SSP_OFS_DATA, {24'h0, pb}); // slave receive
        bus(1, `SSP_OFS_CTRL, 32'h0);
        pins(32'h7); // pins free when off
        $display("test slave done");
        // two-wire with sample phase and edge select clear
        cfg(`SSP_MODE_TWO_WIRE, 1'b0);
        bus(1, `SSP_OFS_INT_CLR, 32'h7);
        peer.cond(1'b1);
        @(posedge ref_clk);
        bus(0, `SSP_OFS_STATUS, 32'h00); // start clears stop
        peer.frame(18);
        @(posedge ref_clk);
        bus(0, `SSP_OFS_STATUS, 32'h20); // data after address
        peer.cond(1'b0);
        @(posedge ref_clk);
        bus(0, `SSP_OFS_STATUS, 32'h30); // stop seen last
        bus(0, `SSP_OFS_INT_STAT, 32'h6); // start and stop events
        bus(1, `SSP_OFS_CTRL, 32'h0);
        bus(0, `SSP_OFS_STATUS, 32'h00); // clear when disabled
        $display("test two-wire done");
        endOfTest();
    end
endmodule // tb_ssp_spi_port
`default_nettype wire
